/* hdl/serial_port_defines.vh */
// register map, field positions, reset values and timing counts
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// register offsets on the 3-bit address port
`define ADR_MODE 3'h0
`define ADR_BAUD 3'h1
`define ADR_CTRL 3'h2
`define ADR_TXDATA 3'h3
`define ADR_STATUS 3'h4
`define ADR_RXDATA 3'h5
`define ADR_PINCTRL 3'h6

// mode_reg fields
`define MODE_SYNC 0
`define MODE_PAR_EN 1
`define MODE_PAR_ODD 2

// control_reg fields
`define CTRL_TXIE 7
`define CTRL_RXIE 6
`define CTRL_XMIT 5
`define CTRL_RCV 4
`define CTRL_DONEIE 2
`define CTRL_CKHI 1
`define CTRL_CKLO 0

// status_reg fields
`define STAT_VAC 7
`define STAT_FULL 6
`define STAT_OVR 5
`define STAT_FRM 4
`define STAT_PAR 3
`define STAT_END 2

// pin_ctrl_reg fields
`define PIN_SEL 0
`define PIN_DIR 1
`define PIN_OUT 2

// reset values
`define MODE_RST 8'h00
`define BAUD_RST 8'h00
`define CTRL_RST 8'h00
`define PIN_RST 8'h00

// timing: index of the last base clock tick in a bit, tick index of mid-bit latch
`define TICKS_LAST 4'hf
`define MID_TICK 4'h7
`define CLK_RISE 4'h8

// frame lengths in bits
`define LEN_ASYNC 4'ha
`define LEN_ASYNC_PAR 4'hb
`define LEN_SYNC 4'h8

`endif

/* hdl/bit_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
   // clock and reset
   input wire mclk_in,
   input wire srst_in,
   // asynchronous level in, synchronised level out
   input wire [WIDTH-1:0] d_in,
   output reg [WIDTH-1:0] q_out
);
   reg [WIDTH-1:0] meta; // first stage, read only by q_out

   // idle line is high, so reset to mark level
   always @(posedge mclk_in) begin
      if (srst_in) begin
         meta <= RESET_VAL;
         q_out <= RESET_VAL;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule

/* hdl/serial_port_unit.v */
// serial port core: flags, requests, transmitter, receiver and pins
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_unit (
   // clock and reset
   input wire mclk_in,
   input wire srst_in,
   // register port
   input wire [2:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   // serial line pins
   input wire serial_in_pin_in,
   output reg serial_out_pin_out,
   output reg serial_out_pin_oe_out,
   output reg serial_clk_pin_out,
   output reg serial_clk_pin_oe_out,
   // interrupt requests
   output reg rx_full_irq_out,
   output reg tx_empty_irq_out,
   output reg tx_done_irq_out,
   output reg rx_error_irq_out
);
   // transmitter states
   localparam [1:0] TX_IDLE = 2'b01;
   localparam [1:0] TX_SEND = 2'b10;
   // receiver states
   localparam [3:0] RX_IDLE = 4'b0001;
   localparam [3:0] RX_START = 4'b0010;
   localparam [3:0] RX_BITS = 4'b0100;
   localparam [3:0] RX_STOP = 4'b1000;

   // software registers
   reg [7:0] mode_reg;
   reg [7:0] baud_reg; // base tick = clock / (baud_reg + 1)
   reg [7:0] control_reg;
   reg [7:0] pin_ctrl_reg;
   reg [7:0] tx_data;
   reg [7:0] rx_data;
   // status flags
   reg tx_buffer_vacant;
   reg rx_buffer_full;
   reg overrun_fault;
   reg frame_fault;
   reg parity_fault;
   reg transmit_end_flag;
   // base clock divider and free bit phase
   reg [7:0] baud_cnt;
   reg [3:0] phase;
   // transmitter
   reg [1:0] tx_state;
   reg [10:0] tx_shifter;
   reg [3:0] tx_left;
   // receiver
   reg [3:0] rx_state;
   reg [3:0] rx_cnt;
   reg [3:0] rx_bit;
   reg [8:0] rx_shifter;
   reg rx_prev;
   // clock pin history for the switch-over glitch
   reg clk_fn_q;
   wire rxd; // synchronised serial input

   // field aliases
   wire sync_mode = mode_reg[`MODE_SYNC];
   wire par_en = mode_reg[`MODE_PAR_EN];
   wire par_odd = mode_reg[`MODE_PAR_ODD];
   wire xmit_on = control_reg[`CTRL_XMIT];
   wire rcv_on = control_reg[`CTRL_RCV];
   wire clk_src_hi = control_reg[`CTRL_CKHI];
   wire txd_pin_select = pin_ctrl_reg[`PIN_SEL];
   wire err_any = overrun_fault | frame_fault | parity_fault;

   // bus decode
   wire tx_wr = wr_in && (addr_in == `ADR_TXDATA);
   wire st_wr = wr_in && (addr_in == `ADR_STATUS);
   wire rx_rd = rd_in && (addr_in == `ADR_RXDATA);

   // timing strobes
   wire tick = (baud_cnt == baud_reg);
   wire bit_end = tick && (phase == `TICKS_LAST);
   wire sync_sample = tick && (phase == `MID_TICK);

   // outgoing frame, lsb first; async frames put the start bit at bit 0, sync frames have none
   wire tx_par = (^tx_data) ^ par_odd;
   wire [10:0] tx_frame = sync_mode ? {3'b111, tx_data} :
      par_en ? {1'b1, tx_par, tx_data, 1'b0} :
      {2'b11, tx_data, 1'b0};
   wire [3:0] tx_len = sync_mode ? `LEN_SYNC :
      par_en ? `LEN_ASYNC_PAR : `LEN_ASYNC;
   // a write in the same cycle defers the load, so no byte is lost
   wire can_load = xmit_on && !tx_buffer_vacant && !tx_wr &&
      !(sync_mode && err_any);
   wire tx_last = (tx_state == TX_SEND) && bit_end && (tx_left == 4'h1);
   wire tx_line = (tx_state == TX_SEND) ? tx_shifter[0] : 1'b1;

   // receiver bit count and completion
   wire [3:0] rx_nbits = (sync_mode || !par_en) ? 4'h8 : 4'h9;
   wire [8:0] rx_next = {rxd, rx_shifter[8:1]};
   wire sync_rx_on = sync_mode && rcv_on && !err_any;
   wire sync_done = sync_mode && (rx_state == RX_BITS) && sync_sample &&
      (rx_bit == 4'h7);
   wire async_done = !sync_mode && (rx_state == RX_STOP) && tick &&
      (rx_cnt == `TICKS_LAST);
   wire fin = rcv_on && (sync_done || async_done);
   wire [7:0] fin_data = sync_done ? rx_next[8:1] :
      par_en ? rx_shifter[7:0] : rx_shifter[8:1];
   wire fin_frm = async_done && !rxd; // stop bit low, also on break
   wire fin_par = async_done && par_en && ((^rx_shifter) != par_odd);

   // synchronous clock pin: output function and its level
   wire clk_fn = sync_mode && !clk_src_hi;
   wire clk_act = (tx_state == TX_SEND) || (rx_state == RX_BITS);
   wire sck = clk_act ? (phase >= `CLK_RISE) : 1'b1;

   // pin input synchroniser
   bit_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_rxd_sync (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .d_in(serial_in_pin_in),
      .q_out(rxd)
   );

   // software register writes
   always @(posedge mclk_in) begin
      if (srst_in) begin
         mode_reg <= `MODE_RST;
         baud_reg <= `BAUD_RST;
         control_reg <= `CTRL_RST;
         pin_ctrl_reg <= `PIN_RST;
         tx_data <= 8'h00;
      end else if (wr_in) begin
         case (addr_in)
            `ADR_MODE: mode_reg <= wdata_in;
            `ADR_BAUD: baud_reg <= wdata_in;
            `ADR_CTRL: control_reg <= wdata_in;
            `ADR_PINCTRL: pin_ctrl_reg <= {5'h00, wdata_in[2:0]};
            `ADR_TXDATA: tx_data <= wdata_in;
            default: ; // status clears are handled with the flags
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge mclk_in) begin
      if (srst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `ADR_MODE: rdata_out <= mode_reg;
            `ADR_BAUD: rdata_out <= baud_reg;
            `ADR_CTRL: rdata_out <= control_reg;
            `ADR_TXDATA: rdata_out <= tx_data;
            `ADR_STATUS: rdata_out <= {tx_buffer_vacant, rx_buffer_full,
               overrun_fault, frame_fault, parity_fault,
               transmit_end_flag, 2'b00};
            `ADR_RXDATA: rdata_out <= rx_data;
            `ADR_PINCTRL: rdata_out <= pin_ctrl_reg;
            default: rdata_out <= 8'h00; // unmapped reads zero
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // base clock at sixteen times the bit rate, free bit phase
   always @(posedge mclk_in) begin
      if (srst_in) begin
         baud_cnt <= 8'h00;
         phase <= 4'h0;
      end else if (tick) begin
         baud_cnt <= 8'h00;
         phase <= phase + 4'h1;
      end else begin
         baud_cnt <= baud_cnt + 8'h01;
      end
   end

   // transmitter and its two flags
   always @(posedge mclk_in) begin
      if (srst_in) begin
         tx_state <= TX_IDLE;
         tx_shifter <= 11'h7ff;
         tx_left <= 4'h0;
         tx_buffer_vacant <= 1'b1;
         transmit_end_flag <= 1'b1;
      end else if (!xmit_on) begin
         // abandon any character in progress; the line returns to mark
         tx_state <= TX_IDLE;
         tx_shifter <= 11'h7ff;
         tx_left <= 4'h0;
         transmit_end_flag <= 1'b1;
         if (tx_wr) begin
            tx_buffer_vacant <= 1'b0;
         end
      end else begin
         if (tx_wr) begin
            tx_buffer_vacant <= 1'b0;
         end
         case (tx_state)
            TX_IDLE: begin
               // loads only on a bit boundary so the first bit is whole
               if (bit_end && can_load) begin
                  tx_shifter <= tx_frame;
                  tx_left <= tx_len;
                  tx_buffer_vacant <= 1'b1;
                  transmit_end_flag <= 1'b0;
                  tx_state <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_last && can_load) begin
                  // back-to-back character, no idle bit between
                  tx_shifter <= tx_frame;
                  tx_left <= tx_len;
                  tx_buffer_vacant <= 1'b1;
               end else if (tx_last) begin
                  tx_state <= TX_IDLE;
                  tx_shifter <= 11'h7ff;
                  tx_left <= 4'h0;
                  if (tx_buffer_vacant) begin
                     transmit_end_flag <= 1'b1;
                  end
               end else if (bit_end) begin
                  tx_shifter <= {1'b1, tx_shifter[10:1]};
                  tx_left <= tx_left - 4'h1;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // receiver sequencing; rcv_on low stops it but leaves the flags
   always @(posedge mclk_in) begin
      if (srst_in) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 4'h0;
         rx_bit <= 4'h0;
         rx_shifter <= 9'h000;
         rx_prev <= 1'b1;
      end else if (!rcv_on) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 4'h0;
         rx_bit <= 4'h0;
         rx_prev <= 1'b1;
      end else if (sync_mode) begin
         // clocked mode: sample as the output clock rises
         case (rx_state)
            RX_BITS: begin
               if (!sync_rx_on) begin
                  rx_state <= RX_IDLE;
               end else if (sync_sample) begin
                  rx_shifter <= rx_next;
                  rx_bit <= (rx_bit == 4'h7) ? 4'h0 : rx_bit + 4'h1;
               end
            end
            default: begin
               rx_bit <= 4'h0;
               if (bit_end && sync_rx_on) begin
                  rx_state <= RX_BITS;
               end else begin
                  rx_state <= RX_IDLE;
               end
            end
         endcase
      end else if (tick) begin
         rx_prev <= rxd;
         case (rx_state)
            RX_IDLE: begin
               // falling edge of the start bit restarts bit timing
               if (rx_prev && !rxd) begin
                  rx_state <= RX_START;
                  rx_cnt <= 4'h0;
               end
            end
            RX_START: begin
               if (rx_cnt == `MID_TICK) begin
                  rx_cnt <= 4'h0;
                  rx_bit <= 4'h0;
                  // a high line at mid start bit was only a glitch
                  rx_state <= rxd ? RX_IDLE : RX_BITS;
               end else begin
                  rx_cnt <= rx_cnt + 4'h1;
               end
            end
            RX_BITS: begin
               // sixteen ticks after mid start is mid of each data bit
               if (rx_cnt == `TICKS_LAST) begin
                  rx_cnt <= 4'h0;
                  rx_shifter <= rx_next;
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == rx_nbits - 4'h1) begin
                     rx_state <= RX_STOP;
                  end
               end else begin
                  rx_cnt <= rx_cnt + 4'h1;
               end
            end
            RX_STOP: begin
               if (rx_cnt == `TICKS_LAST) begin
                  rx_cnt <= 4'h0;
                  // a held-low line keeps receiving as a new frame
                  rx_state <= rxd ? RX_IDLE : RX_START;
               end else begin
                  rx_cnt <= rx_cnt + 4'h1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // receive flags: hardware set wins over a software clear
   always @(posedge mclk_in) begin
      if (srst_in) begin
         rx_buffer_full <= 1'b0;
         overrun_fault <= 1'b0;
         frame_fault <= 1'b0;
         parity_fault <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         if (fin && !rx_buffer_full && !fin_frm && !fin_par) begin
            rx_data <= fin_data;
            rx_buffer_full <= 1'b1;
         end else if (rx_rd) begin
            rx_buffer_full <= 1'b0;
         end else if (st_wr && !wdata_in[`STAT_FULL]) begin
            rx_buffer_full <= 1'b0;
         end
         if (fin && rx_buffer_full) begin
            overrun_fault <= 1'b1;
         end else if (st_wr && !wdata_in[`STAT_OVR]) begin
            overrun_fault <= 1'b0;
         end
         if (fin && fin_frm) begin
            frame_fault <= 1'b1;
         end else if (st_wr && !wdata_in[`STAT_FRM]) begin
            frame_fault <= 1'b0;
         end
         if (fin && fin_par) begin
            parity_fault <= 1'b1;
         end else if (st_wr && !wdata_in[`STAT_PAR]) begin
            parity_fault <= 1'b0;
         end
      end
   end

   // pins; the clock pin pulls low one cycle when leaving sync mode drops its output
   always @(posedge mclk_in) begin
      if (srst_in) begin
         serial_out_pin_out <= 1'b0;
         serial_out_pin_oe_out <= 1'b0;
         serial_clk_pin_out <= 1'b0;
         serial_clk_pin_oe_out <= 1'b0;
         clk_fn_q <= 1'b0;
      end else begin
         clk_fn_q <= clk_fn;
         if (txd_pin_select) begin
            serial_out_pin_out <= tx_line;
            serial_out_pin_oe_out <= 1'b1;
         end else begin
            serial_out_pin_out <= pin_ctrl_reg[`PIN_OUT];
            serial_out_pin_oe_out <= pin_ctrl_reg[`PIN_DIR];
         end
         if (clk_fn) begin
            serial_clk_pin_out <= sck;
            serial_clk_pin_oe_out <= 1'b1;
         end else if (clk_fn_q && !sync_mode) begin
            // switching with clk_src_hi set first avoids this pulse
            serial_clk_pin_out <= 1'b0;
            serial_clk_pin_oe_out <= 1'b1;
         end else begin
            serial_clk_pin_out <= 1'b0;
            serial_clk_pin_oe_out <= 1'b0;
         end
      end
   end

   // request levels, one register stage behind flag and enable
   always @(posedge mclk_in) begin
      if (srst_in) begin
         rx_full_irq_out <= 1'b0;
         tx_empty_irq_out <= 1'b0;
         tx_done_irq_out <= 1'b0;
         rx_error_irq_out <= 1'b0;
      end else begin
         rx_full_irq_out <= rx_buffer_full &
            control_reg[`CTRL_RXIE];
         tx_empty_irq_out <= tx_buffer_vacant &
            control_reg[`CTRL_TXIE];
         tx_done_irq_out <= transmit_end_flag &
            control_reg[`CTRL_DONEIE];
         rx_error_irq_out <= err_any &
            control_reg[`CTRL_RXIE];
      end
   end
endmodule

/* tb/serial_port_properties.sv */
// checker: request gating, pin muxing and clock pin release
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_checker (
   // clock and reset
   input wire mclk_in,
   input wire srst_in,
   // register port
   input wire [2:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] rdata_out,
   // pins
   input wire serial_in_pin_in,
   input wire serial_out_pin_out,
   input wire serial_out_pin_oe_out,
   input wire serial_clk_pin_out,
   input wire serial_clk_pin_oe_out,
   // requests
   input wire rx_full_irq_out,
   input wire tx_empty_irq_out,
   input wire tx_done_irq_out,
   input wire rx_error_irq_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   wire cw = wr_in && addr_in == `ADR_CTRL; // control write
   wire pw = wr_in && addr_in == `ADR_PINCTRL; // pin control write
   wire mw = wr_in && addr_in == `ADR_MODE; // mode write
   reg sel_q; // shadow of pin select
   // shadow needed to know who owns the transmit pin
   always @(posedge mclk_in) begin
      if (srst_in)
         sel_q <= 1'b0;
      else if (pw)
         sel_q <= wdata_in[`PIN_SEL];
   end
   // requests drop on reset whatever the flags
   a_irq_reset: assert property (disable iff (1'b0) srst_in |=>
      !rx_full_irq_out && !tx_empty_irq_out && !tx_done_irq_out &&
      !rx_error_irq_out) else $error("request high after reset");
   // irq lags the enable register by one clock, hence two cycles
   a_empty_gated: assert property (cw && !wdata_in[`CTRL_TXIE] |->
      ##2 !tx_empty_irq_out) else $error("empty request not gated");
   a_done_gated: assert property (cw && !wdata_in[`CTRL_DONEIE] |->
      ##2 !tx_done_irq_out) else $error("end request not gated");
   a_rx_gated: assert property (cw && !wdata_in[`CTRL_RXIE] |->
      ##2 !(rx_full_irq_out || rx_error_irq_out))
      else $error("receive requests not gated");
   // general port pin copies direction and level bits
   a_port_pin: assert property (pw && !wdata_in[`PIN_SEL] ##1 !pw [*2]
      |=> serial_out_pin_oe_out == $past(wdata_in[`PIN_DIR], 3) &&
      serial_out_pin_out == $past(wdata_in[`PIN_OUT], 3))
      else $error("port pin wrong");
   a_pin_drive: assert property (pw && wdata_in[`PIN_SEL] ##1 !pw [*2]
      |=> serial_out_pin_oe_out) else $error("transmit pin not driven");
   a_abort_idle: assert property (cw && !wdata_in[`CTRL_XMIT] && sel_q
      |-> ##3 serial_out_pin_out && serial_out_pin_oe_out)
      else $error("line not idle after transmit off");
   a_clk_glitch: assert property (mw && !wdata_in[`MODE_SYNC] &&
      serial_clk_pin_oe_out |-> ##[1:3] (serial_clk_pin_oe_out &&
      !serial_clk_pin_out) ##1 !serial_clk_pin_oe_out)
      else $error("clock pin release wrong");
   // main scenarios reached
   c_error: cover property (rx_error_irq_out);
   c_full: cover property (rx_full_irq_out);
   c_end: cover property (tx_done_irq_out && tx_empty_irq_out);
   c_glitch: cover property (serial_clk_pin_oe_out && !serial_clk_pin_out);
endmodule
bind serial_port_unit serial_port_checker u_chk (
   .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .serial_in_pin_in(serial_in_pin_in),
   .serial_out_pin_out(serial_out_pin_out),
   .serial_out_pin_oe_out(serial_out_pin_oe_out),
   .serial_clk_pin_out(serial_clk_pin_out),
   .serial_clk_pin_oe_out(serial_clk_pin_oe_out),
   .rx_full_irq_out(rx_full_irq_out), .tx_empty_irq_out(tx_empty_irq_out),
   .tx_done_irq_out(tx_done_irq_out), .rx_error_irq_out(rx_error_irq_out));

/* tb/serial_peer.sv */
// remote line partner: frame sender and frame catcher
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   // clock
   input wire mclk_in,
   // line from the unit, released level already resolved
   input wire tx_line_in,
   // line towards the unit
   output logic rx_line_out,
   // caught character
   output logic [7:0] got_out,
   output logic got_stb_out
);
   int i; // catcher bit index
   logic [7:0] sh; // catcher shift
   // idle line is mark level
   initial begin
      rx_line_out = 1'b1;
      got_out = 8'h00;
      got_stb_out = 1'b0;
   end
   // start, eight data lsb first, stop; calls chain with no gap
   task send(input logic [7:0] d);
      logic [9:0] f;
      int k;
      f = {1'b1, d, 1'b0};
      for (k = 0; k < 10; k++) begin
         @(posedge mclk_in);
         rx_line_out <= f[k];
         repeat (BIT_CLKS - 1) @(posedge mclk_in);
      end
   endtask
   // hold a level, low for a break
   task hold(input logic v);
      @(posedge mclk_in);
      rx_line_out <= v;
   endtask
   // catcher: start edge then mid-bit samples, stop not judged
   always begin
      @(negedge tx_line_in);
      repeat (BIT_CLKS / 2) @(posedge mclk_in);
      for (i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge mclk_in);
         sh[i] = tx_line_in;
      end
      got_out <= sh;
      got_stb_out <= 1'b1;
      @(posedge mclk_in);
      got_stb_out <= 1'b0;
   end
endmodule

/* tb/serial_port_unit_tb_top.sv */
// testbench: register driver, line partner, queued checks
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_unit_tb_top;
   logic mclk_in = 1'b0; // 100 ns clock
   logic srst_in = 1'b1; // held two cycles
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   wire [7:0] rdata_out, got;
   wire rx_line, tx_out, tx_oe, ck_out, ck_oe, got_stb;
   wire rx_full, tx_empty, tx_done, rx_err;
   wire [3:0] irqs = {rx_err, tx_done, tx_empty, rx_full}; // by index
   wire tx_line = tx_oe ? tx_out : 1'b1; // released pin pulled up
   int error_cnt = 0;
   int cmp_count = 0;
   logic [15:0] rd_q[$]; // mask and value per read
   logic [7:0] tx_q[$]; // bytes due on the line
   logic [15:0] e; // popped note
   logic rd_d = 1'b0; // read taken last edge
   logic [7:0] b[8]; // random characters
   logic ck_d = 1'b1; // clock pin one edge ago, released reads high
   logic [7:0] sy = 8'h00; // bits caught on clock pin rises
   int sn = 0; // clock pin rises seen
   int glc = 0; // cycles the clock pin is driven low
   int g0; // glc before a clock pin hand-back
   serial_port_unit u_dut (.mclk_in(mclk_in), .srst_in(srst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .serial_in_pin_in(rx_line),
      .serial_out_pin_out(tx_out), .serial_out_pin_oe_out(tx_oe),
      .serial_clk_pin_out(ck_out), .serial_clk_pin_oe_out(ck_oe),
      .rx_full_irq_out(rx_full), .tx_empty_irq_out(tx_empty),
      .tx_done_irq_out(tx_done), .rx_error_irq_out(rx_err));
   serial_peer u_peer (.mclk_in(mclk_in), .tx_line_in(tx_line),
      .rx_line_out(rx_line), .got_out(got), .got_stb_out(got_stb));
   // clock
   initial forever #50 mclk_in = ~mclk_in;
   task chk(input logic [7:0] got_v, input logic [7:0] exp_v);
      cmp_count++;
      if (got_v !== exp_v) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, got_v, exp_v);
      end
   endtask
   task end_sim;
      $display("mismatches %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one-cycle write strobe, a free edge before the next access
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   // read strobe; the expected value waits in the queue
   task rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      rd_q.push_back({m, v});
      @(posedge mclk_in);
      rd_in <= 1'b0;
   endtask
   task nc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // bounded wait for a request; the caller judges the outcome
   task wt(input int i, input int n);
      int k;
      for (k = 0; k < n && irqs[i] !== 1'b1; k++) @(negedge mclk_in);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge mclk_in) rd_d <= rd_in;
   // watcher: settled outputs at the falling edge
   always @(negedge mclk_in) begin
      if (rd_d) begin
         e = rd_q.pop_front();
         chk(rdata_out & e[15:8], e[7:0]);
      end
      if (got_stb && tx_q.size() > 0)
         chk(got, tx_q.pop_front());
   end
   // clocked mode catcher: one data bit per rise of a driven clock
   always @(posedge mclk_in) begin
      ck_d <= ck_out | !ck_oe;
      if (ck_oe && ck_out && !ck_d) begin
         sy <= {tx_line, sy[7:1]};
         sn <= sn + 1;
      end
   end
   // low clock pin cycles, so the hand-back pulse can be counted
   always @(negedge mclk_in)
      if (ck_oe === 1'b1 && ck_out === 1'b0) glc++;
   // watchdog, well past the few thousand cycles needed
   initial begin
      repeat (20000) @(posedge mclk_in);
      error_cnt++;
      end_sim;
   end
   initial begin
      void'($urandom(37901));
      foreach (b[j]) b[j] = 8'($urandom);
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'b0;
      // reset values, unmapped address reads zero
      rd(`ADR_STATUS, 8'hfc, 8'h84);
      rd(3'h7, 8'hff, 8'h00);
      rd(`ADR_CTRL, 8'hff, `CTRL_RST);
      rd(`ADR_PINCTRL, 8'hff, `PIN_RST);
      // empty and end requests before any data
      wr(`ADR_CTRL, 8'h84);
      nc(3);
      chk(irqs[1], 1'b1);
      chk(irqs[2], 1'b1);
      wr(`ADR_CTRL, 8'h04);
      nc(3);
      chk(irqs[1], 1'b0);
      // two characters back to back
      wr(`ADR_PINCTRL, 8'h01);
      wr(`ADR_CTRL, 8'h24);
      wr(`ADR_TXDATA, b[0]);
      tx_q.push_back(b[0]);
      wr(`ADR_CTRL, 8'ha4);
      wt(1, 40);
      chk(irqs[1], 1'b1);
      wr(`ADR_TXDATA, b[1]);
      tx_q.push_back(b[1]);
      wr(`ADR_CTRL, 8'h24);
      nc(3);
      chk(irqs[2], 1'b0);
      wt(2, 400);
      chk(irqs[2], 1'b1);
      chk(8'(tx_q.size()), 8'h00);
      // abort in mid-character
      wr(`ADR_TXDATA, b[2]);
      nc(60);
      wr(`ADR_CTRL, 8'h04);
      nc(3);
      chk(tx_line, 1'b1);
      chk(irqs[2], 1'b1);
      // one good character in
      wr(`ADR_CTRL, 8'h50);
      u_peer.send(b[3]);
      wt(0, 60);
      chk(irqs[0], 1'b1);
      rd(`ADR_RXDATA, 8'hff, b[3]);
      nc(3);
      chk(irqs[0], 1'b0);
      rd(`ADR_STATUS, 8'h40, 8'h00);
      // second character lost to overrun
      u_peer.send(b[4]);
      u_peer.send(b[5]);
      wt(3, 60);
      chk(irqs[3], 1'b1);
      rd(`ADR_STATUS, 8'h60, 8'h60);
      rd(`ADR_RXDATA, 8'hff, b[4]);
      wr(`ADR_STATUS, 8'hdf);
      nc(3);
      chk(irqs[3], 1'b0);
      // break: frame fault returns after clearing
      u_peer.hold(1'b0);
      wt(3, 300);
      chk(irqs[3], 1'b1);
      wr(`ADR_STATUS, 8'hef);
      nc(3);
      chk(irqs[3], 1'b0);
      wt(3, 300);
      chk(irqs[3], 1'b1);
      u_peer.hold(1'b1);
      nc(200);
      wr(`ADR_CTRL, 8'h40);
      nc(3);
      chk(irqs[3], 1'b1);
      rd(`ADR_STATUS, 8'h10, 8'h10);
      // synchronous mode: error flags hold transmit back
      wr(`ADR_MODE, 8'h01);
      wr(`ADR_CTRL, 8'ha4);
      wr(`ADR_TXDATA, b[6]);
      nc(60);
      chk(irqs[1], 1'b0);
      rd(`ADR_STATUS, 8'h80, 8'h00);
      wr(`ADR_STATUS, 8'h87);
      wt(1, 60);
      chk(irqs[1], 1'b1);
      chk(irqs[2], 1'b0);
      wt(2, 300);
      chk(irqs[2], 1'b1);
      chk(sy, b[6]);
      chk(8'(sn), 8'h08);
      // clock pin handed back
      chk(ck_oe, 1'b1);
      g0 = glc;
      wr(`ADR_MODE, 8'h00);
      nc(4);
      chk(ck_oe, 1'b0);
      chk(8'(glc - g0), 8'h01);
      // break through the port pin, transmitter still on
      wr(`ADR_PINCTRL, 8'h03);
      wr(`ADR_PINCTRL, 8'h02);
      nc(3);
      chk(tx_line, 1'b0);
      wr(`ADR_CTRL, 8'h00);
      wr(`ADR_PINCTRL, 8'h06);
      nc(3);
      chk(tx_line, 1'b1);
      // clock pin released in one control write, then mode left
      wr(`ADR_MODE, 8'h01);
      nc(2);
      chk(ck_oe, 1'b1);
      g0 = glc;
      wr(`ADR_CTRL, 8'h02);
      wr(`ADR_MODE, 8'h00);
      nc(4);
      chk(ck_oe, 1'b0);
      chk(8'(glc - g0), 8'h00);
      end_sim;
   end
endmodule
